// *** rms_and_phase_calibration.sv ***
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "level_params.svh"
module rms_and_phase_calibration (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // samples, one strobe for all six channels
  input wire logic SAMPLE_VALID,
  input wire logic signed [23:0] I_SAMPLE_A,
  input wire logic signed [23:0] I_SAMPLE_B,
  input wire logic signed [23:0] I_SAMPLE_C,
  input wire logic signed [23:0] V_SAMPLE_A,
  input wire logic signed [23:0] V_SAMPLE_B,
  input wire logic signed [23:0] V_SAMPLE_C,
  // delayed voltage samples for the power path
  output logic signed [23:0] V_DELAYED_A,
  output logic signed [23:0] V_DELAYED_B,
  output logic signed [23:0] V_DELAYED_C,
  // register port
  input wire logic [5:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [23:0] RDATA
);
  typedef struct packed {
    logic [2:0][4:0] delay_trim;
    logic [2:0][11:0] power_gain;
    logic [2:0][11:0] ioffset;
    logic [2:0][11:0] voltage_gain;
    logic gain_mode;
    logic [15:0] xtalk_trim;
    logic [3:0] div;
    logic [4:0] wr_ptr;
    logic [2:0][23:0] vdel;
    logic [5:0][47:0] acc;
    logic [5:0][23:0] level;
    logic [2:0] ch;
    logic [4:0] bit_idx;
    logic [47:0] rad;
    logic [47:0] rem_v;
    logic [23:0] root;
    level_pkg::sqrt_state_t st;
    logic [23:0] rdata;
  } state_t;

  state_t s;
  state_t n;
  // history of voltage samples, one ring per phase
  logic signed [23:0] vhist [0:2][0:`DELAY_DEPTH-1];

  function automatic logic [4:0] tap(input logic [4:0] wp, input logic [4:0] trim);
    // base delay of 16 samples; trim adds or removes samples
    tap = wp - (`DELAY_BASE + trim);
  endfunction : tap

  // multiplier is 1 + g/4096, kept signed so 800h..7ffh give -50%..+50%
  function automatic logic signed [23:0] gain_apply(input logic signed [23:0] x,
                                                    input logic [11:0] g);
    logic signed [13:0] m;
    logic signed [37:0] p;
    m = 14'sd4096 + 14'($signed(g));
    p = x * m;
    gain_apply = p[35:12];
  endfunction : gain_apply

  // gain on the square, so the root moves by sqrt(1 + g/4096)
  function automatic logic signed [47:0] gain_sq(input logic signed [47:0] x,
                                                 input logic [11:0] g);
    logic signed [13:0] m;
    logic signed [61:0] p;
    m = 14'sd4096 + 14'($signed(g));
    p = x * m;
    gain_sq = p[59:12];
  endfunction : gain_sq

  always_ff @(posedge REF_CLK)
  begin
    if (SAMPLE_VALID)
    begin
      vhist[0][s.wr_ptr] <= V_SAMPLE_A;
      vhist[1][s.wr_ptr] <= V_SAMPLE_B;
      vhist[2][s.wr_ptr] <= V_SAMPLE_C;
    end
  end

  always_comb
  begin
    logic signed [23:0] smp;
    logic signed [47:0] sq;
    logic [47:0] trial;
    logic signed [48:0] adj;
    smp = 24'sh000000;
    sq = 48'sh000000000000;
    trial = 48'h000000000000;
    adj = 49'sh0000000000000;
    n = s;
    n.rdata = 24'h000000;
    if (WR)
    begin
      case (ADDR)
        `OFF_XTALK_TRIM: n.xtalk_trim = WDATA[15:0];
        `OFF_MODE: n.gain_mode = WDATA[0];
        default:
        begin
          for (int k = 0; k < 3; k++)
          begin
            if (ADDR == `OFF_DELAY_A + 6'(k)) n.delay_trim[k] = WDATA[4:0];
            if (ADDR == `OFF_GAIN_A + 6'(k)) n.power_gain[k] = WDATA[11:0];
            if (ADDR == `OFF_IOFS_A + 6'(k)) n.ioffset[k] = WDATA[11:0];
            if (ADDR == `OFF_VOLTAGE_GAIN_A + 6'(k)) n.voltage_gain[k] = WDATA[11:0];
          end
        end
      endcase
    end
    if (RD)
    begin
      // reads only copy state out
      case (ADDR)
        `OFF_XTALK_TRIM: n.rdata = {8'h00, s.xtalk_trim};
        `OFF_MODE: n.rdata = {23'h000000, s.gain_mode};
        default:
        begin
          for (int k = 0; k < 3; k++)
          begin
            if (ADDR == `OFF_DELAY_A + 6'(k)) n.rdata = {19'h00000, s.delay_trim[k]};
            if (ADDR == `OFF_GAIN_A + 6'(k)) n.rdata = {12'h000, s.power_gain[k]};
            if (ADDR == `OFF_IOFS_A + 6'(k)) n.rdata = {12'h000, s.ioffset[k]};
            if (ADDR == `OFF_VOLTAGE_GAIN_A + 6'(k)) n.rdata = {12'h000, s.voltage_gain[k]};
            if (ADDR == `OFF_ILEVEL_A + 6'(k)) n.rdata = s.level[k];
            if (ADDR == `OFF_VLEVEL_A + 6'(k)) n.rdata = s.level[k+3];
          end
        end
      endcase
    end
    // square and low-pass all six channels together
    if (SAMPLE_VALID)
    begin
      n.wr_ptr = s.wr_ptr + 5'd1;
      for (int k = 0; k < 3; k++)
        n.vdel[k] = vhist[k][tap(s.wr_ptr, s.delay_trim[k])];
      for (int c = 0; c < 6; c++)
      begin
        case (c)
          0: smp = I_SAMPLE_A;
          1: smp = I_SAMPLE_B;
          2: smp = I_SAMPLE_C;
          3: smp = gain_apply(V_SAMPLE_A, s.voltage_gain[0]);
          4: smp = gain_apply(V_SAMPLE_B, s.voltage_gain[1]);
          default: smp = gain_apply(V_SAMPLE_C, s.voltage_gain[2]);
        endcase
        sq = smp * smp;
        // current gain folded in squared domain: sqrt(1+g) on result
        if (c < 3 && s.gain_mode)
          sq = gain_sq(sq, s.power_gain[c]);
        n.acc[c] = s.acc[c] - (s.acc[c] >> `FILTER_SHIFT) + (48'(sq) >> `FILTER_SHIFT);
      end
    end
    // shared square root, one channel per result slot
    n.div = (s.div == `RATE_DIV - 4'd1) ? 4'd0 : s.div + 4'd1;
    case (s.st)
      level_pkg::IDLE:
      begin
        if (s.div == 4'd0)
        begin
          adj = $signed({1'b0, s.acc[s.ch]});
          if (s.ch < 3'd3)
            adj = adj + ($signed({{37{s.ioffset[s.ch][11]}}, s.ioffset[s.ch]})
                  <<< `IOFS_SCALE_SHIFT);
          n.rad = adj[48] ? 48'h0 : adj[47:0];
          n.rem_v = 48'h0;
          n.root = 24'h0;
          n.bit_idx = 5'd23;
          n.st = level_pkg::SQRT_RUN;
        end
      end
      level_pkg::SQRT_RUN:
      begin
        trial = {s.root, 24'h0} >> (23 - s.bit_idx);
        trial = s.rem_v + trial + (48'h1 << (2 * s.bit_idx));
        if (trial <= s.rad)
        begin
          n.rem_v = trial;
          n.root = s.root | (24'h1 << s.bit_idx);
        end
        if (s.bit_idx == 5'd0)
        begin
          // voltage result carries 8 fraction bits
          n.level[s.ch] = (s.ch >= 3'd3) ? (n.root << `VOUT_SHIFT) : n.root;
          n.ch = (s.ch == 3'd5) ? 3'd0 : s.ch + 3'd1;
          n.st = level_pkg::IDLE;
        end
        else
          n.bit_idx = s.bit_idx - 5'd1;
      end
      default: n.st = level_pkg::IDLE;
    endcase
    if (SRST)
    begin
      n = '0;
      n.st = level_pkg::IDLE;
    end
  end

  always_ff @(posedge REF_CLK)
    s <= n;

  // voltage delay centred so zero trim matches current path
  assign V_DELAYED_A = s.vdel[0];
  assign V_DELAYED_B = s.vdel[1];
  assign V_DELAYED_C = s.vdel[2];
  assign RDATA = s.rdata;
endmodule : rms_and_phase_calibration

// *** level_params.svh ***
// Function
// - 5-bit signed per-phase voltage delay trim
// - negative trim advances, positive delays voltage
// - rms: square, low-pass, square root
// - six channels filtered concurrently, one shared square root, separate result registers
// - current level unsigned 24-bit, sample-scaled
// - current results refresh at clock/216
// - full-scale current sine reads about 5931641
// - power gain scales current by sqrt(1+g/4096)
// - current offset: sqrt(rms^2 + offset*32768)
// - voltage rms after voltage gain applied
// - voltage level unsigned 24-bit, 256 per LSB
// - voltage results refresh at clock/216
// - full-scale voltage wraps: 5a8279 << 8 reads about 827900
// - no added current/voltage phase skew
`ifndef LEVEL_PARAMS_SVH
`define LEVEL_PARAMS_SVH
`define ADDR_W 6
`define OFF_XTALK_TRIM 6'h3d
`define OFF_DELAY_A 6'h20
`define OFF_GAIN_A 6'h24
`define OFF_IOFS_A 6'h28
`define OFF_VOLTAGE_GAIN_A 6'h2c
`define OFF_ILEVEL_A 6'h30
`define OFF_VLEVEL_A 6'h34
`define OFF_MODE 6'h38
`define RATE_DIV 4'd12
`define DELAY_BASE 5'd16
`define DELAY_DEPTH 32
`define FILTER_SHIFT 5'd12
`define IOFS_SCALE_SHIFT 15
`define VOLTAGE_GAIN_SHIFT 12
`define VOUT_SHIFT 8
`endif

// *** level_pkg.sv ***
package level_pkg;
  typedef logic signed [23:0] sample_t;
  typedef logic [23:0] level_t;
  typedef enum logic [1:0] {IDLE, SQRT_RUN} sqrt_state_t;
endpackage : level_pkg

// *** rms_and_phase_calibration_checker.sv ***
`timescale 1ns/100ps
module rms_level_checker (
  // clock, reset, strobes
  input wire logic REF_CLK, SRST, SAMPLE_VALID, WR, RD,
  // register port
  input wire logic [5:0] ADDR,
  input wire logic [23:0] WDATA, RDATA,
  // delayed voltage
  input wire logic signed [23:0] V_DELAYED_A, V_DELAYED_B, V_DELAYED_C
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 24'h0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (RD && ADDR == 6'h3f |=> RDATA == 24'h0)
    else $error("unmapped read not zero");
  AST_XTALK_RB: assert property (WR && ADDR == 6'h3d ##1 RD && ADDR == 6'h3d
    |=> RDATA[15:0] == $past(WDATA[15:0], 2)) else $error("trim readback");
  AST_DELAY_RB: assert property (WR && ADDR == 6'h20 ##1 RD && ADDR == 6'h20
    |=> RDATA[4:0] == $past(WDATA[4:0], 2)) else $error("delay trim readback");
  AST_GAIN_RB: assert property (WR && ADDR == 6'h25 ##1 RD && ADDR == 6'h25
    |=> RDATA[11:0] == $past(WDATA[11:0], 2)) else $error("gain readback");
  AST_OFS_RB: assert property (WR && ADDR == 6'h2a ##1 RD && ADDR == 6'h2a
    |=> RDATA[11:0] == $past(WDATA[11:0], 2)) else $error("offset readback");
  AST_HOLD: assert property (!$past(SAMPLE_VALID) && !$past(SRST)
    |-> $stable({V_DELAYED_A, V_DELAYED_B, V_DELAYED_C})) else $error("delay moved");
  AST_RST_ZERO: assert property ($past(SRST) |-> RDATA == 24'h0 && V_DELAYED_A == 24'sh0)
    else $error("not cleared by reset");
endmodule : rms_level_checker
bind rms_and_phase_calibration rms_level_checker chk_u (.*);

// *** tb_rms_and_phase_calibration.sv ***
`timescale 1ns/100ps
module tb_rms_and_phase_calibration;
  logic REF_CLK = 0, SRST = 1, SAMPLE_VALID = 0, WR = 0, RD = 0;
  logic signed [23:0] I_SAMPLE_A = 0, I_SAMPLE_B = 0, I_SAMPLE_C = 0;
  logic signed [23:0] V_SAMPLE_A = 0, V_SAMPLE_B = 0, V_SAMPLE_C = 0;
  logic signed [23:0] V_DELAYED_A, V_DELAYED_B, V_DELAYED_C;
  logic [5:0] ADDR = 0;
  logic [23:0] WDATA = 0, RDATA, got;
  logic [4:0] trims [3] = '{5'h00, 5'h1c, 5'h03};
  int n_mismatch = 0, n_checks = 0, d;
  // address, value written, value read back
  // only 01f7 ever goes to the trim register; phase trims stay small
  logic [23:0] rows [7][3] = '{'{24'h3d, 24'h1f7, 24'h1f7}, '{24'h20, 24'h1c, 24'h1c},
    '{24'h25, 24'h7ff, 24'h7ff}, '{24'h2a, 24'h7ff, 24'h7ff}, '{24'h38, 24'h1, 24'h1},
    '{24'h3f, 24'h5a, 24'h0}, '{24'h30, 24'h123, 24'h0}};
  rms_and_phase_calibration dut_u (.*);
  initial forever #4 REF_CLK = ~REF_CLK;
  task check(input logic [23:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s exp %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : check
  task wr(input logic [5:0] a, input logic [23:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge REF_CLK) WR <= 1'b0;
  endtask : wr
  task rd(input logic [5:0] a);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK) RD <= 1'b0;
    #1 got = RDATA;
  endtask : rd
  task feed;
    SAMPLE_VALID <= 1'b1;
    @(posedge REF_CLK) SAMPLE_VALID <= 1'b0;
    @(posedge REF_CLK);
  endtask : feed
  // roots are inexact: allow one percent plus two codes
  task lvl(input logic [5:0] a, input int e, input string what);
    rd(a);
    check({23'h0, got + e / 100 + 2 >= e && got <= e + e / 100 + 2}, 24'h1, what);
  endtask : lvl
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    #600000 n_mismatch++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge REF_CLK);
    SRST <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i][0][5:0], rows[i][1]);
      rd(rows[i][0][5:0]);
      check(got, rows[i][2], "register");
    end
    $display("test registers done");
    foreach (trims[t])
    begin
      @(posedge REF_CLK) wr(6'h20, {19'h0, trims[t]});
      d = 16 + int'($signed(trims[t]));
      for (int k = 0; k < 40; k++)
      begin
        V_SAMPLE_A <= 24'(k + 1);
        feed;
        #1 if (k >= d) check(V_DELAYED_A, 24'(k - d + 1), "delayed voltage");
      end
    end
    $display("test delay done");
    @(posedge REF_CLK) I_SAMPLE_A <= 24'sd1000;
    I_SAMPLE_B <= 24'sd500;
    V_SAMPLE_A <= 24'sd1000;
    repeat (25000) feed;
    repeat (200) @(posedge REF_CLK);
    lvl(6'h30, 1000, "current a");
    lvl(6'h31, 612, "current b");
    lvl(6'h32, 8190, "current c");
    lvl(6'h34, 256000, "voltage a");
    lvl(6'h35, 0, "voltage b");
    $display("test levels done");
    SRST <= 1'b1;
    @(posedge REF_CLK) SRST <= 1'b0;
    rd(6'h30);
    check(got, 24'h0, "level after reset");
    rd(6'h3d);
    check(got, 24'h0, "trim after reset");
    $display("test reset done");
    give_verdict;
  end
endmodule : tb_rms_and_phase_calibration
